// ==== src/sergrp_params.svh ====
// Constants for the status event reporting groups: command codes, bit map, masks, defaults.
`ifndef SERGRP_PARAMS_SVH
`define SERGRP_PARAMS_SVH

// Register width of every status register.
`define SERGRP_REG_W            16
`define SERGRP_CMD_W            5

// Command codes. Codes 01 to 08 address the operation group, 09 to 10 the questionable group.
`define SERGRP_CMD_NOP          5'h00
`define SERGRP_CMD_OP_COND_RD   5'h01
`define SERGRP_CMD_OP_RISE_WR   5'h02
`define SERGRP_CMD_OP_RISE_RD   5'h03
`define SERGRP_CMD_OP_FALL_WR   5'h04
`define SERGRP_CMD_OP_FALL_RD   5'h05
`define SERGRP_CMD_OP_EVT_RD    5'h06
`define SERGRP_CMD_OP_ENA_WR    5'h07
`define SERGRP_CMD_OP_ENA_RD    5'h08
`define SERGRP_CMD_QU_COND_RD   5'h09
`define SERGRP_CMD_QU_RISE_WR   5'h0A
`define SERGRP_CMD_QU_RISE_RD   5'h0B
`define SERGRP_CMD_QU_FALL_WR   5'h0C
`define SERGRP_CMD_QU_FALL_RD   5'h0D
`define SERGRP_CMD_QU_EVT_RD    5'h0E
`define SERGRP_CMD_QU_ENA_WR    5'h0F
`define SERGRP_CMD_QU_ENA_RD    5'h10
`define SERGRP_CMD_CLEAR_STATUS 5'h11
`define SERGRP_CMD_PRESET       5'h12

// Operation group bit positions.
`define SERGRP_OP_CALIBRATING   0
`define SERGRP_OP_MEASURING     4
`define SERGRP_OP_STATISTICS    8
`define SERGRP_OP_INT_REF       9
`define SERGRP_OP_IN_LIMIT      10

// Masks of condition bits (filtered) and of all usable bits per group.
`define SERGRP_OP_COND_MASK     16'h0311
`define SERGRP_OP_USED_MASK     16'h0711
`define SERGRP_QU_COND_MASK     16'h7FFF
`define SERGRP_QU_USED_MASK     16'h7FFF

// Status byte positions of the two summary bits.
`define SERGRP_SB_OPERATION     7
`define SERGRP_SB_QUESTIONABLE  3

// Default number of measurements per statistics block.
`define SERGRP_STATS_N_DEFAULT  16'h0064

`endif

// ==== src/sergrp_pkg.sv ====
// Types shared by the status event reporting groups.
package sergrp_pkg;
  `include "sergrp_params.svh"

  typedef logic [`SERGRP_REG_W-1:0] sergrp_word_t;

  typedef enum logic [1:0] {
    SERGRP_ST_IDLE    = 2'b01,
    SERGRP_ST_COLLECT = 2'b10
  } sergrp_stats_state_t;
endpackage

// ==== src/sergrp_group.sv ====
// One status group: transition filters, sticky event register, enable register, summary.
`timescale 1ns/100ps
module sergrp_group
  import sergrp_pkg::*;
#(
  parameter int          WIDTH     = 16,
  parameter logic [15:0] COND_MASK = 16'h7FFF,
  parameter logic [15:0] USED_MASK = 16'h7FFF
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Live condition and direct event sources
  input  wire logic [WIDTH-1:0] cond,
  input  wire logic [WIDTH-1:0] direct_set,
  // Commands
  input  wire logic             wr_rise,
  input  wire logic             wr_fall,
  input  wire logic             wr_enable,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             clr_event,
  input  wire logic             preset,
  // Register contents
  output logic      [WIDTH-1:0] rise_q,
  output logic      [WIDTH-1:0] fall_q,
  output logic      [WIDTH-1:0] enable_q,
  output logic      [WIDTH-1:0] event_q,
  output logic                  summary_q
);

  if (WIDTH != 16)
  begin : g_width_check
    $error("sergrp_group supports only 16-bit status registers");
  end

  logic [WIDTH-1:0] cond_prev_q;
  logic [WIDTH-1:0] cond_prev_d;
  logic [WIDTH-1:0] rise_d;
  logic [WIDTH-1:0] fall_d;
  logic [WIDTH-1:0] enable_d;
  logic [WIDTH-1:0] event_d;
  logic [WIDTH-1:0] set_bits;
  logic             summary_d;

  always_comb
  begin
    cond_prev_d = cond & COND_MASK;
    rise_d      = rise_q;
    fall_d      = fall_q;
    enable_d    = enable_q;
    // Filters survive clear-status and queries; only preset or a write changes them.
    if (preset)
    begin
      rise_d = COND_MASK;
      fall_d = '0;
    end
    else
    begin
      if (wr_rise)
        rise_d = wdata & COND_MASK;
      if (wr_fall)
        fall_d = wdata & COND_MASK;
    end
    if (preset)
      enable_d = '0;
    else if (wr_enable)
      enable_d = wdata & USED_MASK;
    // Rising edges pass the positive filter, falling edges the negative one.
    set_bits = ((cond_prev_d & ~cond_prev_q & rise_q)
              | (~cond_prev_d & cond_prev_q & fall_q)
              | (direct_set & ~COND_MASK))
              & USED_MASK;
    // A new event in the clearing cycle is kept, so nothing is lost by a read.
    event_d   = (clr_event ? '0 : event_q) | set_bits;
    // Summary is registered from the next values, so it matches the registers every cycle.
    summary_d = |(event_d & enable_d);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // Track the live condition through reset, so its level is not taken as an edge.
      cond_prev_q <= cond_prev_d;
      rise_q      <= COND_MASK;
      fall_q      <= '0;
      enable_q    <= '0;
      event_q     <= '0;
      summary_q   <= 1'b0;
    end
    else
    begin
      cond_prev_q <= cond_prev_d;
      rise_q      <= rise_d;
      fall_q      <= fall_d;
      enable_q    <= enable_d;
      event_q     <= event_d;
      summary_q   <= summary_d;
    end
  end

endmodule

// ==== src/sergrp_top.sv ====
// Operation and questionable status reporting groups with their command port.
//
// Functional notes
// - Two groups, each with five status registers.
// - Condition registers follow hardware status continuously.
// - Reading a condition register has no effects.
// - Positive filter alone: event on rising condition.
// - Negative filter alone: event on falling condition.
// - Both filters set: event on any change.
// - Both filters clear: no transition events reported.
// - Filters kept by clear and queries, preset reloads.
// - Event bits stay set until read or cleared.
// - Event query returns then clears; clear-status clears.
// - Only enabled events reach the summary bit.
// - Preset and power-on clear enable registers.
// - Bit 0 high while calibrating.
// - Bit 4 high while measuring.
// - Missing selected external reference suppresses measuring bit.
// - Bit 8 high across an N-measurement statistics block.
// - Bit 9 high while internal reference used.
// - Bit 10 set on each passed limit test.
// - In-limit event bypasses the transition filters.
// - Bit 15 of every register reads zero.
// - Operation summary drives status byte bit 7.
// - Questionable summary drives status byte bit 3.
`timescale 1ns/100ps
`include "sergrp_params.svh"
module sergrp_top
  import sergrp_pkg::*;
#(
  parameter int STATS_W = 16
)
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Command port from the remote interface parser
  input  wire logic                      cmd_valid,
  input  wire logic [`SERGRP_CMD_W-1:0]  cmd_code,
  input  wire logic [`SERGRP_REG_W-1:0]  cmd_wdata,
  output logic                           rsp_valid_q,
  output logic      [`SERGRP_REG_W-1:0]  rsp_data_q,
  // Instrument state pins, asynchronous to sys_clk
  input  wire logic                      calibrating_pin,
  input  wire logic                      measuring_pin,
  input  wire logic                      ext_ref_explicit_pin,
  input  wire logic                      ref_auto_pin,
  input  wire logic                      ext_ref_present_pin,
  input  wire logic [`SERGRP_REG_W-1:0]  quest_cond_pin,
  // On-chip sources on sys_clk
  input  wire logic                      stats_enable,
  input  wire logic [STATS_W-1:0]        stats_count,
  input  wire logic                      limit_pass,
  input  wire logic [`SERGRP_REG_W-1:0]  quest_event_set,
  // Summary outputs toward the status byte
  output logic                           operation_summary_bit_q,
  output logic                           questionable_summary_bit_q,
  output logic      [7:0]                status_byte_bits_q
);

  if (STATS_W < 1 || STATS_W > 32)
  begin : g_stats_w_check
    $error("sergrp_top STATS_W must be 1 to 32");
  end

  // Two-stage synchronisers for all pins, left unreset so that no false edge follows reset.
  localparam int PIN_W = 5 + `SERGRP_REG_W;
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic [PIN_W-1:0] pin_raw;

  assign pin_raw = {quest_cond_pin, ext_ref_present_pin, ref_auto_pin,
                    ext_ref_explicit_pin, measuring_pin, calibrating_pin};

  always_ff @(posedge sys_clk)
  begin
    pin_meta_q <= pin_raw;
    pin_sync_q <= pin_meta_q;
  end

  logic                     cal_s;
  logic                     meas_s;
  logic                     ext_explicit_s;
  logic                     ref_auto_s;
  logic                     ext_present_s;
  logic [`SERGRP_REG_W-1:0] quest_cond_s;

  assign cal_s          = pin_sync_q[0];
  assign meas_s         = pin_sync_q[1];
  assign ext_explicit_s = pin_sync_q[2];
  assign ref_auto_s     = pin_sync_q[3];
  assign ext_present_s  = pin_sync_q[4];
  assign quest_cond_s   = pin_sync_q[PIN_W-1:5];

  // Reference and measuring qualification.
  logic ext_in_use;
  logic meas_reported;

  always_comb
  begin
    // Automatic selection takes the external reference only while it is present.
    if (ref_auto_s)
      ext_in_use = ext_present_s;
    else
      ext_in_use = ext_explicit_s;
    // A missing explicitly chosen reference hides measuring, only while automatic selection is off.
    meas_reported = meas_s & ~(~ref_auto_s & ext_explicit_s & ~ext_present_s);
  end

  // Statistics block tracking: counts finished measurements up to the block size.
  sergrp_stats_state_t  stats_state_q;
  sergrp_stats_state_t  stats_state_d;
  logic [STATS_W-1:0]   stats_done_q;
  logic [STATS_W-1:0]   stats_done_d;
  logic                 meas_prev_q;
  logic                 meas_prev_d;
  logic                 meas_start;
  logic                 meas_end;

  always_comb
  begin
    meas_prev_d   = meas_reported;
    meas_start    = meas_reported & ~meas_prev_q;
    meas_end      = ~meas_reported & meas_prev_q;
    stats_state_d = stats_state_q;
    stats_done_d  = stats_done_q;
    case (stats_state_q)
      SERGRP_ST_IDLE:
      begin
        if (stats_enable && meas_start)
        begin
          stats_state_d = SERGRP_ST_COLLECT;
          stats_done_d  = '0;
        end
      end
      SERGRP_ST_COLLECT:
      begin
        if (!stats_enable)
          stats_state_d = SERGRP_ST_IDLE;
        else if (meas_end)
        begin
          // A block size of zero or one ends with the first finished measurement.
          if (stats_done_q + STATS_W'(1) >= stats_count)
            stats_state_d = SERGRP_ST_IDLE;
          else
            stats_done_d = stats_done_q + STATS_W'(1);
        end
      end
      default:
      begin
        stats_state_d = SERGRP_ST_IDLE;
        stats_done_d  = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stats_state_q <= SERGRP_ST_IDLE;
      stats_done_q  <= '0;
      meas_prev_q   <= 1'b0;
    end
    else
    begin
      stats_state_q <= stats_state_d;
      stats_done_q  <= stats_done_d;
      meas_prev_q   <= meas_prev_d;
    end
  end

  // Operation condition register, rebuilt every cycle from the live state.
  logic [`SERGRP_REG_W-1:0] op_cond;
  logic [`SERGRP_REG_W-1:0] op_direct;

  always_comb
  begin
    op_cond                         = '0;
    op_cond[`SERGRP_OP_CALIBRATING] = cal_s;
    op_cond[`SERGRP_OP_MEASURING]   = meas_reported;
    op_cond[`SERGRP_OP_STATISTICS]  = (stats_state_q == SERGRP_ST_COLLECT);
    op_cond[`SERGRP_OP_INT_REF]     = ~ext_in_use;
    op_direct                       = '0;
    op_direct[`SERGRP_OP_IN_LIMIT]  = limit_pass;
  end

  // Command decode into one-cycle strobes.
  logic cmd_cls;
  logic cmd_preset;
  logic op_rise_wr;
  logic op_fall_wr;
  logic op_ena_wr;
  logic op_evt_rd;
  logic qu_rise_wr;
  logic qu_fall_wr;
  logic qu_ena_wr;
  logic qu_evt_rd;

  always_comb
  begin
    cmd_cls    = cmd_valid && (cmd_code == `SERGRP_CMD_CLEAR_STATUS);
    cmd_preset = cmd_valid && (cmd_code == `SERGRP_CMD_PRESET);
    op_rise_wr = cmd_valid && (cmd_code == `SERGRP_CMD_OP_RISE_WR);
    op_fall_wr = cmd_valid && (cmd_code == `SERGRP_CMD_OP_FALL_WR);
    op_ena_wr  = cmd_valid && (cmd_code == `SERGRP_CMD_OP_ENA_WR);
    op_evt_rd  = cmd_valid && (cmd_code == `SERGRP_CMD_OP_EVT_RD);
    qu_rise_wr = cmd_valid && (cmd_code == `SERGRP_CMD_QU_RISE_WR);
    qu_fall_wr = cmd_valid && (cmd_code == `SERGRP_CMD_QU_FALL_WR);
    qu_ena_wr  = cmd_valid && (cmd_code == `SERGRP_CMD_QU_ENA_WR);
    qu_evt_rd  = cmd_valid && (cmd_code == `SERGRP_CMD_QU_EVT_RD);
  end

  // The two groups.
  logic [`SERGRP_REG_W-1:0] op_rise;
  logic [`SERGRP_REG_W-1:0] op_fall;
  logic [`SERGRP_REG_W-1:0] op_ena;
  logic [`SERGRP_REG_W-1:0] op_evt;
  logic                     op_sum;
  logic [`SERGRP_REG_W-1:0] qu_rise;
  logic [`SERGRP_REG_W-1:0] qu_fall;
  logic [`SERGRP_REG_W-1:0] qu_ena;
  logic [`SERGRP_REG_W-1:0] qu_evt;
  logic                     qu_sum;

  sergrp_group #(
    .WIDTH     (`SERGRP_REG_W),
    .COND_MASK (`SERGRP_OP_COND_MASK),
    .USED_MASK (`SERGRP_OP_USED_MASK)
  ) u_operation (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .cond       (op_cond),
    .direct_set (op_direct),
    .wr_rise    (op_rise_wr),
    .wr_fall    (op_fall_wr),
    .wr_enable  (op_ena_wr),
    .wdata      (cmd_wdata),
    .clr_event  (op_evt_rd | cmd_cls),
    .preset     (cmd_preset),
    .rise_q     (op_rise),
    .fall_q     (op_fall),
    .enable_q   (op_ena),
    .event_q    (op_evt),
    .summary_q  (op_sum)
  );

  sergrp_group #(
    .WIDTH     (`SERGRP_REG_W),
    .COND_MASK (`SERGRP_QU_COND_MASK),
    .USED_MASK (`SERGRP_QU_USED_MASK)
  ) u_questionable (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .cond       (quest_cond_s & `SERGRP_QU_COND_MASK),
    .direct_set (quest_event_set),
    .wr_rise    (qu_rise_wr),
    .wr_fall    (qu_fall_wr),
    .wr_enable  (qu_ena_wr),
    .wdata      (cmd_wdata),
    .clr_event  (qu_evt_rd | cmd_cls),
    .preset     (cmd_preset),
    .rise_q     (qu_rise),
    .fall_q     (qu_fall),
    .enable_q   (qu_ena),
    .event_q    (qu_evt),
    .summary_q  (qu_sum)
  );

  // Query answers, one cycle after the command. The event answer is the value
  // before the clear, so no event escapes between read and clear.
  logic                     rsp_valid_d;
  logic [`SERGRP_REG_W-1:0] rsp_data_d;

  always_comb
  begin
    rsp_valid_d = 1'b0;
    rsp_data_d  = '0;
    if (cmd_valid)
    begin
      rsp_valid_d = 1'b1;
      case (cmd_code)
        `SERGRP_CMD_OP_COND_RD: rsp_data_d = op_cond;
        `SERGRP_CMD_OP_RISE_RD: rsp_data_d = op_rise;
        `SERGRP_CMD_OP_FALL_RD: rsp_data_d = op_fall;
        `SERGRP_CMD_OP_EVT_RD:  rsp_data_d = op_evt;
        `SERGRP_CMD_OP_ENA_RD:  rsp_data_d = op_ena;
        `SERGRP_CMD_QU_COND_RD: rsp_data_d = quest_cond_s & `SERGRP_QU_COND_MASK;
        `SERGRP_CMD_QU_RISE_RD: rsp_data_d = qu_rise;
        `SERGRP_CMD_QU_FALL_RD: rsp_data_d = qu_fall;
        `SERGRP_CMD_QU_EVT_RD:  rsp_data_d = qu_evt;
        `SERGRP_CMD_QU_ENA_RD:  rsp_data_d = qu_ena;
        default:                rsp_valid_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
    end
    else
    begin
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q  <= rsp_data_d & 16'h7FFF;
    end
  end

  // Summary bits into the status byte, registered once more after the group summary flops.
  logic [7:0] sb_d;

  always_comb
  begin
    sb_d                          = '0;
    sb_d[`SERGRP_SB_OPERATION]    = op_sum;
    sb_d[`SERGRP_SB_QUESTIONABLE] = qu_sum;
  end

  assign operation_summary_bit_q    = op_sum;
  assign questionable_summary_bit_q = qu_sum;

  // Kept as a flop copy of the group summaries; lags them by one cycle.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status_byte_bits_q <= '0;
    else
      status_byte_bits_q <= sb_d;
  end

endmodule

// ==== verification/sergrp_top_props.sv ====
// Port-level checker for the status reporting groups, with its bind.
`timescale 1ns/100ps
`include "sergrp_params.svh"
module sergrp_top_props
  import sergrp_pkg::*;
(
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rst,
  // Command port
  input wire logic                     cmd_valid,
  input wire logic [`SERGRP_CMD_W-1:0] cmd_code,
  input wire logic                     rsp_valid_q,
  input wire logic [`SERGRP_REG_W-1:0] rsp_data_q,
  // Instrument state
  input wire logic                     calibrating_pin,
  input wire logic                     measuring_pin,
  input wire logic                     ext_ref_explicit_pin,
  input wire logic                     ref_auto_pin,
  input wire logic                     ext_ref_present_pin,
  input wire logic                     limit_pass,
  // Summaries
  input wire logic                     operation_summary_bit_q,
  input wire logic                     questionable_summary_bit_q,
  input wire logic [7:0]               status_byte_bits_q
);
  logic rd_cmd;
  logic op_rd;
  logic cond_rd;

  always_comb
  begin
    op_rd   = cmd_valid && (cmd_code inside {5'h01, 5'h03, 5'h05, 5'h06, 5'h08});
    rd_cmd  = op_rd || (cmd_valid && (cmd_code inside {5'h09, 5'h0B, 5'h0D, 5'h0E, 5'h10}));
    cond_rd = cmd_valid && (cmd_code == `SERGRP_CMD_OP_COND_RD);
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_evt_query;
    cmd_valid && (cmd_code == `SERGRP_CMD_OP_EVT_RD) && !limit_pass;
  endsequence

  property p_rsp_follows_read;
    rd_cmd |=> rsp_valid_q;
  endproperty
  a_rsp_follows_read: assert property (p_rsp_follows_read) else $error("read gave no answer");
  property p_rsp_only_read;
    rsp_valid_q |-> $past(rd_cmd);
  endproperty
  a_rsp_only_read: assert property (p_rsp_only_read) else $error("answer without read");
  property p_op_unused_zero;
    op_rd |=> (rsp_data_q & 16'hF8EE) == 16'h0000;
  endproperty
  a_op_unused_zero: assert property (p_op_unused_zero) else $error("unused bit set");
  property p_sb_operation;
    1'b1 |=> status_byte_bits_q[7] == $past(operation_summary_bit_q);
  endproperty
  a_sb_operation: assert property (p_sb_operation) else $error("status byte bit 7 wrong");
  property p_sb_questionable;
    1'b1 |=> status_byte_bits_q[3] == $past(questionable_summary_bit_q);
  endproperty
  a_sb_questionable: assert property (p_sb_questionable) else $error("status bit 3 wrong");
  property p_sb_others;
    (status_byte_bits_q & 8'h77) == 8'h00;
  endproperty
  a_sb_others: assert property (p_sb_others) else $error("spare status byte bit set");
  property p_preset_summary;
    cmd_valid && (cmd_code == `SERGRP_CMD_PRESET) |=>
      !operation_summary_bit_q && !questionable_summary_bit_q;
  endproperty
  a_preset_summary: assert property (p_preset_summary) else $error("summary after preset");
  property p_limit_event;
    limit_pass ##1 s_evt_query |=> rsp_valid_q && rsp_data_q[10];
  endproperty
  a_limit_event: assert property (p_limit_event) else $error("limit event lost");
  property p_event_cleared;
    s_evt_query ##1 !limit_pass ##1 s_evt_query |=> !rsp_data_q[10];
  endproperty
  a_event_cleared: assert property (p_event_cleared) else $error("event not cleared");
  property p_cal_cond;
    ($stable(calibrating_pin))[*4] ##0 cond_rd |=> rsp_data_q[0] == $past(calibrating_pin);
  endproperty
  a_cal_cond: assert property (p_cal_cond) else $error("calibrating bit wrong");
  property p_meas_ref_cond;
    ($stable({measuring_pin, ext_ref_explicit_pin, ref_auto_pin, ext_ref_present_pin}))[*4]
      ##0 cond_rd |=>
      rsp_data_q[4] == $past(measuring_pin & ~(~ref_auto_pin & ext_ref_explicit_pin
                                               & ~ext_ref_present_pin)) &&
      rsp_data_q[9] == $past(ref_auto_pin ? ~ext_ref_present_pin : ~ext_ref_explicit_pin);
  endproperty
  a_meas_ref_cond: assert property (p_meas_ref_cond) else $error("measuring or ref bit wrong");
endmodule

bind sergrp_top sergrp_top_props u_props (
  .sys_clk                    (sys_clk),
  .rst                        (rst),
  .cmd_valid                  (cmd_valid),
  .cmd_code                   (cmd_code),
  .rsp_valid_q                (rsp_valid_q),
  .rsp_data_q                 (rsp_data_q),
  .calibrating_pin            (calibrating_pin),
  .measuring_pin              (measuring_pin),
  .ext_ref_explicit_pin       (ext_ref_explicit_pin),
  .ref_auto_pin               (ref_auto_pin),
  .ext_ref_present_pin        (ext_ref_present_pin),
  .limit_pass                 (limit_pass),
  .operation_summary_bit_q    (operation_summary_bit_q),
  .questionable_summary_bit_q (questionable_summary_bit_q),
  .status_byte_bits_q         (status_byte_bits_q)
);

// ==== verification/sergrp_ctrl_model.sv ====
// Behavioural remote controller that issues status commands and takes query answers.
`timescale 1ns/100ps
`include "sergrp_params.svh"
module sergrp_ctrl_model
  import sergrp_pkg::*;
(
  // Clock
  input  wire logic                     sys_clk,
  // Command port toward the groups
  output logic                          cmd_valid,
  output logic      [`SERGRP_CMD_W-1:0] cmd_code,
  output sergrp_word_t                  cmd_wdata,
  input  wire logic                     rsp_valid_q,
  input  wire sergrp_word_t             rsp_data_q
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = 5'h00;
    cmd_wdata = 16'h0000;
  end

  // Idle code and data lines carry the inverse of the last command, so a design
  // that samples them without the strobe sees garbage rather than stale values.
  task automatic send(input logic [`SERGRP_CMD_W-1:0] code, input sergrp_word_t wd);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_wdata = wd;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~wd;
  endtask

  // The answer stands for one cycle only, so it is taken at once; none reads as unknown.
  task automatic query(input logic [`SERGRP_CMD_W-1:0] code, output sergrp_word_t rd);
    send(code, 16'h5A5A);
    rd = rsp_valid_q ? rsp_data_q : 16'hXXXX;
  endtask
endmodule

// ==== verification/sergrp_tb_top.sv ====
// Self-checking testbench for the status reporting groups.
`timescale 1ns/100ps
`include "sergrp_params.svh"
module sergrp_tb_top
  import sergrp_pkg::*;
;
  logic                     sys_clk;
  logic                     rst;
  logic                     cmd_valid;
  logic [`SERGRP_CMD_W-1:0] cmd_code;
  sergrp_word_t             cmd_wdata;
  logic                     rsp_valid_q;
  sergrp_word_t             rsp_data_q;
  logic                     calibrating_pin = 1'b0;
  logic                     measuring_pin = 1'b0;
  logic                     ext_ref_explicit_pin = 1'b1;
  logic                     ref_auto_pin = 1'b0;
  logic                     ext_ref_present_pin = 1'b1;
  sergrp_word_t             quest_cond_pin = 16'h0000;
  logic                     stats_enable = 1'b0;
  logic [15:0]              stats_count = 16'h0002;
  logic                     limit_pass = 1'b0;
  logic                     op_sum;
  logic                     qu_sum;
  logic [7:0]               sb;
  int                       bad_count = 0;
  int                       cmp_count = 0;

  sergrp_top uut (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .calibrating_pin(calibrating_pin), .measuring_pin(measuring_pin),
    .ext_ref_explicit_pin(ext_ref_explicit_pin), .ref_auto_pin(ref_auto_pin),
    .ext_ref_present_pin(ext_ref_present_pin), .quest_cond_pin(quest_cond_pin),
    .stats_enable(stats_enable), .stats_count(stats_count), .limit_pass(limit_pass),
    .quest_event_set(16'h0000), .operation_summary_bit_q(op_sum),
    .questionable_summary_bit_q(qu_sum), .status_byte_bits_q(sb)
  );

  sergrp_ctrl_model u_ctrl (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q)
  );

  task automatic chk(input sergrp_word_t got, input sergrp_word_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [`SERGRP_CMD_W-1:0] code, input sergrp_word_t exp);
    sergrp_word_t v;
    u_ctrl.query(code, v);
    chk(v, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial
  begin
    wt(5000);
    bad_count++;
    complete_run();
  end

  initial
  begin
    sergrp_word_t w;
    rst = 1'b1;
    wt(6);
    rst = 1'b0;
    wt(2);
    rd(`SERGRP_CMD_OP_RISE_RD, 16'h0311);
    rd(`SERGRP_CMD_QU_RISE_RD, 16'h7FFF);
    rd(`SERGRP_CMD_OP_FALL_RD, 16'h0000);
    rd(`SERGRP_CMD_OP_ENA_RD, 16'h0000);
    $display("test reset values done");
    for (int m = 0; m < 4; m++)
    begin
      u_ctrl.send(`SERGRP_CMD_OP_RISE_WR, {15'h0000, m[0]});
      u_ctrl.send(`SERGRP_CMD_OP_FALL_WR, {15'h0000, m[1]});
      calibrating_pin = 1'b1;
      wt(5);
      rd(`SERGRP_CMD_OP_COND_RD, 16'h0001);
      rd(`SERGRP_CMD_OP_EVT_RD, {15'h0000, m[0]});
      calibrating_pin = 1'b0;
      wt(5);
      rd(`SERGRP_CMD_OP_EVT_RD, {15'h0000, m[1]});
    end
    $display("test filter modes done");
    u_ctrl.send(`SERGRP_CMD_PRESET, 16'h0000);
    rd(`SERGRP_CMD_OP_RISE_RD, 16'h0311);
    rd(`SERGRP_CMD_OP_FALL_RD, 16'h0000);
    u_ctrl.send(`SERGRP_CMD_OP_ENA_WR, 16'hFFFF);
    rd(`SERGRP_CMD_OP_ENA_RD, 16'h0711);
    calibrating_pin = 1'b1;
    wt(5);
    calibrating_pin = 1'b0;
    wt(5);
    chk({15'h0000, op_sum}, 16'h0001);
    chk({8'h00, sb}, 16'h0080);
    u_ctrl.send(`SERGRP_CMD_OP_RISE_WR, 16'h0011);
    u_ctrl.send(`SERGRP_CMD_CLEAR_STATUS, 16'h0000);
    chk({15'h0000, op_sum}, 16'h0000);
    rd(`SERGRP_CMD_OP_RISE_RD, 16'h0011);
    rd(`SERGRP_CMD_OP_EVT_RD, 16'h0000);
    u_ctrl.send(`SERGRP_CMD_PRESET, 16'h0000);
    rd(`SERGRP_CMD_OP_RISE_RD, 16'h0311);
    rd(`SERGRP_CMD_OP_ENA_RD, 16'h0000);
    $display("test sticky summary done");
    u_ctrl.send(`SERGRP_CMD_OP_RISE_WR, 16'h0000);
    limit_pass = 1'b1;
    fork
      begin
        wt(1);
        limit_pass = 1'b0;
      end
      rd(`SERGRP_CMD_OP_EVT_RD, 16'h0400);
    join
    rd(`SERGRP_CMD_OP_EVT_RD, 16'h0000);
    $display("test limit event done");
    for (int m = 0; m < 16; m++)
    begin
      {measuring_pin, ext_ref_explicit_pin, ref_auto_pin, ext_ref_present_pin} = m[3:0];
      wt(5);
      w = 16'h0000;
      w[4] = m[3] & ~(~m[1] & m[2] & ~m[0]);
      w[9] = m[1] ? ~m[0] : ~m[2];
      rd(`SERGRP_CMD_OP_COND_RD, w);
    end
    $display("test measuring and reference done");
    {measuring_pin, ext_ref_explicit_pin, ref_auto_pin, ext_ref_present_pin} = 4'h1;
    stats_enable = 1'b1;
    wt(5);
    for (int m = 0; m < 2; m++)
    begin
      measuring_pin = 1'b1;
      wt(5);
      rd(`SERGRP_CMD_OP_COND_RD, 16'h0310);
      measuring_pin = 1'b0;
      wt(5);
      rd(`SERGRP_CMD_OP_COND_RD, (m == 0) ? 16'h0300 : 16'h0200);
    end
    $display("test statistics done");
    u_ctrl.send(`SERGRP_CMD_PRESET, 16'h0000);
    u_ctrl.send(`SERGRP_CMD_QU_ENA_WR, 16'hFFFF);
    rd(`SERGRP_CMD_QU_ENA_RD, 16'h7FFF);
    quest_cond_pin = 16'hFFFF;
    wt(5);
    rd(`SERGRP_CMD_QU_COND_RD, 16'h7FFF);
    chk({8'h00, sb}, 16'h0008);
    chk({15'h0000, qu_sum}, 16'h0001);
    rd(`SERGRP_CMD_QU_EVT_RD, 16'h7FFF);
    chk({15'h0000, qu_sum}, 16'h0000);
    u_ctrl.send(5'h1F, 16'h1234);
    $display("test questionable done");
    complete_run();
  end
endmodule
